// file: src/event_cross.sv
// Toggle-based crossing of single-cycle events between two clock domains
`timescale 1ns/10ps
`default_nettype none
module event_cross #(
   parameter int WIDTH = 1
) (
   // Source side
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic [WIDTH-1:0] src_pulse,
   // Destination side
   input wire logic dst_clk,
   input wire logic dst_rst,
   output logic [WIDTH-1:0] dst_pulse
);
   logic [WIDTH-1:0] tog_reg;
   logic [WIDTH-1:0] tog_next;
   logic [WIDTH-1:0] tog_sync;
   logic [WIDTH-1:0] seen_reg;
   logic [WIDTH-1:0] pulse_reg;

   // Each event flips its toggle once
   always_comb begin
      tog_next = tog_reg ^ src_pulse;
   end

   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         tog_reg <= '0;
      end else begin
         tog_reg <= tog_next;
      end
   end

   sync_filter #(.WIDTH(WIDTH), .INIT('0)) tog_sync_u (
      .clk(dst_clk),
      .rst(dst_rst),
      .d(tog_reg),
      .q(tog_sync)
   );

   // A change of the synchronised toggle is one event
   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         seen_reg <= '0;
         pulse_reg <= '0;
      end else begin
         seen_reg <= tog_sync;
         pulse_reg <= tog_sync ^ seen_reg;
      end
   end

   assign dst_pulse = pulse_reg;
endmodule
`default_nettype wire

// file: src/i2c_slave_pkg.sv
// Shared constants and types of the two-wire slave transfer engine
package i2c_slave_pkg;
   // ****************************************
   // Widths and field positions
   // ****************************************
   localparam int ADDR_W = 10;
   localparam int BYTE_W = 8;
   localparam int RW_POS = 0;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam int SYNC_STAGES = 3;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic SCL_RELEASE_RST = 1'b1;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // ****************************************
   // Engine states, Gray along the ten-bit write path
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ADDR_LO = 3'h3,
      ST_RX = 3'h2,
      ST_TX = 3'h6,
      ST_SKIP = 3'h4
   } engine_state_t;
endpackage

// file: src/i2c_slave_stretch_engine.sv
// Slave transfer engine of a two-wire serial controller with clock stretching
//
// Contract
// - Read address: acknowledge, empty buffer holds clock until release set
// - Transmit shifts eight bits, data changes on falls
// - Transmit event pulse at ninth fall always
// - Write address: receive, sample on rising clock
// - Byte done, buffer empty: load and acknowledge
// - Buffer full: no acknowledge, keep buffer, pulse
// - Overflow set, buffer empty: load, not acknowledge
// - Ten-bit first byte write match: pulse, clear match
// - First byte mismatch or read without match: clear, idle
// - Second byte match sets match, else idle
// - After full match, read restart starts transmit
// - Transmit ack with empty buffer clears release
// - Transmit stretch ignores receive stretch enable
// - Buffer loaded before ninth fall: no stretch
// - Software may set release at any time
// - Receive stretch on full buffer clears release
// - Buffer read before ninth fall: no stretch
// - Ten-bit address bytes stretch, then per byte
// - Seven-bit compare own address with upper bits
// - Address match acknowledges, pulses, buffer untouched
// - Release clear ignored with stretching disabled
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_stretch_engine (
   // Clocks and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic link_clk,
   // Serial pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Configuration
   input wire logic [i2c_slave_pkg::ADDR_W-1:0] own_address,
   input wire logic ten_bit_address_mode,
   input wire logic rx_stretch_enable,
   // Processor requests
   input wire logic tx_write,
   input wire logic [i2c_slave_pkg::BYTE_W-1:0] tx_data,
   input wire logic rx_read,
   input wire logic scl_release_set,
   input wire logic scl_release_clear,
   input wire logic rx_overflow_clear,
   // Processor status
   output logic [i2c_slave_pkg::BYTE_W-1:0] rx_buffer,
   output logic tx_buffer_full,
   output logic rx_buffer_full,
   output logic rx_overflow,
   output logic scl_release,
   output logic full_ten_bit_match,
   output logic addressed_state,
   output logic slave_event_flag
);
   import i2c_slave_pkg::*;

   // ****************************************
   // Crossings
   // ****************************************
   logic lrst;
   logic scl_f, sda_f;
   logic [ADDR_W-1:0] own_s;
   logic ten_s, rx_stretch_enable_s;
   logic wr_ev, rd_ev, rel_set_ev, rel_clr_ev, ov_clr_ev;
   logic ev_reg;
   logic [5:0] stat_s;
   logic [BYTE_W-1:0] tx_hold_reg;
   logic [BYTE_W-1:0] rx_word_reg;
   logic [BYTE_W-1:0] rx_buf_reg;
   logic rbf_seen_reg;

   // Link-side reset follows the core reset
   sync_filter #(.WIDTH(1), .INIT(1'b1)) rst_sync_u (
      .clk(link_clk), .rst(1'b0), .d(rst), .q(lrst)
   );

   sync_filter #(.WIDTH(2), .INIT(2'h3)) pin_sync_u (
      .clk(link_clk), .rst(lrst), .d({scl_in, sda_in}), .q({scl_f, sda_f})
   );

   sync_filter #(.WIDTH(ADDR_W + 2), .INIT('0)) cfg_sync_u (
      .clk(link_clk),
      .rst(lrst),
      .d({own_address, ten_bit_address_mode, rx_stretch_enable}),
      .q({own_s, ten_s, rx_stretch_enable_s})
   );

   event_cross #(.WIDTH(5)) req_cross_u (
      .src_clk(core_clk),
      .src_rst(rst),
      .src_pulse({tx_write, rx_read, scl_release_set, scl_release_clear, rx_overflow_clear}),
      .dst_clk(link_clk),
      .dst_rst(lrst),
      .dst_pulse({wr_ev, rd_ev, rel_set_ev, rel_clr_ev, ov_clr_ev})
   );

   event_cross #(.WIDTH(1)) ev_cross_u (
      .src_clk(link_clk),
      .src_rst(lrst),
      .src_pulse(ev_reg),
      .dst_clk(core_clk),
      .dst_rst(rst),
      .dst_pulse(slave_event_flag)
   );

   // ****************************************
   // Link engine state
   // ****************************************
   engine_state_t st_reg, st_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [BYTE_W-1:0] shift_reg, shift_next;
   logic [BYTE_W-1:0] rx_word_next;
   logic [BYTE_W-1:0] tx_word_reg, tx_word_next;
   logic [BYTE_W-1:0] tx_shift_reg, tx_shift_next;
   logic tbf_reg, tbf_next, rbf_reg, rbf_next, ov_reg, ov_next;
   logic rel_reg, rel_next, match_reg, match_next;
   logic ack_reg, ack_next, ack_smp_reg, ack_smp_next;
   logic pend_reg, pend_next, sda_oe_reg, sda_oe_next;
   logic scl_oe_reg, scl_oe_next, ev_next;
   logic scl_q_reg, sda_q_reg;
   logic rise, fall, start_det, stop_det, ninth, byte_done;
   logic m7, m10h, rw;

   // Bus events from the filtered pins
   assign rise = scl_f && !scl_q_reg;
   assign fall = !scl_f && scl_q_reg;
   assign start_det = scl_f && scl_q_reg && sda_q_reg && !sda_f;
   assign stop_det = scl_f && scl_q_reg && !sda_q_reg && sda_f;
   assign ninth = fall && (cnt_reg == ACK_SLOT) && (st_reg != ST_IDLE);
   assign byte_done = fall && (cnt_reg == LAST_BIT) && (st_reg != ST_IDLE);
   assign rw = shift_reg[RW_POS];
   assign m7 = shift_reg[7:1] == own_s[6:0];
   assign m10h = (shift_reg[7:3] == TEN_BIT_PREFIX) && (shift_reg[2:1] == own_s[9:8]);

   // Next state of the link engine
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      rx_word_next = rx_word_reg;
      tx_word_next = tx_word_reg;
      tx_shift_next = tx_shift_reg;
      tbf_next = tbf_reg;
      rbf_next = rbf_reg;
      ov_next = ov_reg;
      rel_next = rel_reg;
      match_next = match_reg;
      ack_next = ack_reg;
      ack_smp_next = ack_smp_reg;
      pend_next = pend_reg;
      sda_oe_next = sda_oe_reg;
      ev_next = 1'b0;
      // Software clears come first so hardware sets win
      if (rd_ev) begin
         rbf_next = 1'b0;
      end
      if (ov_clr_ev) begin
         ov_next = 1'b0;
      end
      if (rel_clr_ev && rx_stretch_enable_s) begin
         rel_next = 1'b0;
      end
      if (stop_det) begin
         st_next = ST_IDLE;
         sda_oe_next = 1'b0;
         rel_next = 1'b1;
         pend_next = 1'b0;
         ack_next = 1'b0;
      end else if (start_det) begin
         st_next = ST_ADDR;
         // The clock fall that closes the start brings the count to zero
         cnt_next = 4'hF;
         sda_oe_next = 1'b0;
         pend_next = 1'b0;
         ack_next = 1'b0;
      end else begin
         // Receive bits are taken on the rising clock
         if (rise && cnt_reg < ACK_SLOT && st_reg != ST_TX && st_reg != ST_IDLE) begin
            shift_next = {shift_reg[6:0], sda_f};
         end
         if (rise && cnt_reg == ACK_SLOT && st_reg == ST_TX) begin
            ack_smp_next = !sda_f;
         end
         if (ninth) begin
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
            ack_next = 1'b0;
            unique case (st_reg)
               ST_ADDR: begin
                  ev_next = 1'b1;
                  if (ten_s && !rw) begin
                     st_next = ST_ADDR_LO;
                     rel_next = rx_stretch_enable_s ? 1'b0 : rel_next;
                  end else if (rw) begin
                     st_next = ST_TX;
                     pend_next = 1'b1;
                     rel_next = tbf_reg ? rel_next : 1'b0;
                  end else begin
                     st_next = ST_RX;
                     rel_next = (rx_stretch_enable_s && rbf_reg) ? 1'b0 : rel_next;
                  end
               end
               ST_ADDR_LO: begin
                  ev_next = 1'b1;
                  st_next = ST_RX;
                  rel_next = rx_stretch_enable_s ? 1'b0 : rel_next;
               end
               ST_RX: begin
                  ev_next = 1'b1;
                  rel_next = (rx_stretch_enable_s && rbf_next) ? 1'b0 : rel_next;
               end
               ST_TX: begin
                  ev_next = 1'b1;
                  if (ack_smp_reg) begin
                     pend_next = 1'b1;
                     rel_next = tbf_reg ? rel_next : 1'b0;
                  end else begin
                     st_next = ST_SKIP;
                  end
               end
               ST_SKIP: begin
                  st_next = ST_SKIP;
               end
               default: begin
                  st_next = ST_IDLE;
               end
            endcase
         end else if (fall && st_reg != ST_IDLE) begin
            cnt_next = cnt_reg + 4'h1;
            if (st_reg == ST_TX) begin
               // Next bit appears while the clock is low
               tx_shift_next = {tx_shift_reg[6:0], 1'b1};
               sda_oe_next = (cnt_reg == LAST_BIT) ? 1'b0 : !tx_shift_reg[6];
            end
            if (byte_done) begin
               unique case (st_reg)
                  ST_ADDR: begin
                     if (ten_s) begin
                        ack_next = m10h && (!rw || match_reg);
                        if (!m10h || (rw && !match_reg)) begin
                           match_next = 1'b0;
                           st_next = ST_IDLE;
                        end else if (!rw) begin
                           match_next = 1'b0;
                        end
                     end else begin
                        ack_next = m7;
                        st_next = m7 ? ST_ADDR : ST_IDLE;
                     end
                  end
                  ST_ADDR_LO: begin
                     ack_next = shift_reg == own_s[7:0];
                     match_next = ack_next;
                     st_next = ack_next ? ST_ADDR_LO : ST_IDLE;
                  end
                  ST_RX: begin
                     if (rbf_reg) begin
                        ack_next = 1'b0;
                        ov_next = 1'b1;
                     end else begin
                        rx_word_next = shift_reg;
                        rbf_next = 1'b1;
                        ack_next = !ov_reg;
                     end
                  end
                  default: begin
                     ack_next = 1'b0;
                  end
               endcase
               sda_oe_next = ack_next;
            end
         end
         // Load the transmit shifter once data or release is present
         if (st_reg == ST_TX && pend_reg && !fall && (tbf_reg || rel_reg)) begin
            tx_shift_next = tbf_reg ? tx_word_reg : IDLE_BYTE;
            tbf_next = 1'b0;
            sda_oe_next = tbf_reg ? !tx_word_reg[7] : 1'b0;
            pend_next = 1'b0;
         end
      end
      // Software sets win over hardware clears
      if (wr_ev) begin
         tbf_next = 1'b1;
         tx_word_next = tx_hold_reg;
      end
      if (rel_set_ev) begin
         rel_next = 1'b1;
      end
      // Hold the clock low only once it is seen low
      scl_oe_next = (!rel_next || pend_next) && (scl_oe_reg || !scl_f);
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         st_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= BYTE_RST;
         rx_word_reg <= BYTE_RST;
         tx_word_reg <= BYTE_RST;
         tx_shift_reg <= IDLE_BYTE;
         tbf_reg <= 1'b0;
         rbf_reg <= 1'b0;
         ov_reg <= 1'b0;
         rel_reg <= SCL_RELEASE_RST;
         match_reg <= 1'b0;
         ack_reg <= 1'b0;
         ack_smp_reg <= 1'b0;
         pend_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         ev_reg <= 1'b0;
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         rx_word_reg <= rx_word_next;
         tx_word_reg <= tx_word_next;
         tx_shift_reg <= tx_shift_next;
         tbf_reg <= tbf_next;
         rbf_reg <= rbf_next;
         ov_reg <= ov_next;
         rel_reg <= rel_next;
         match_reg <= match_next;
         ack_reg <= ack_next;
         ack_smp_reg <= ack_smp_next;
         pend_reg <= pend_next;
         sda_oe_reg <= sda_oe_next;
         scl_oe_reg <= scl_oe_next;
         ev_reg <= ev_next;
         scl_q_reg <= scl_f;
         sda_q_reg <= sda_f;
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_oe_reg;
   assign sda_oe = sda_oe_reg;

   // ****************************************
   // Core side
   // ****************************************
   // Release reads as set while reset, every other flag clear
   sync_filter #(.WIDTH(6), .INIT(6'h08)) stat_sync_u (
      .clk(core_clk),
      .rst(rst),
      .d({tbf_reg, rbf_reg, rel_reg, ov_reg, match_reg,
          (st_reg == ST_RX) || (st_reg == ST_TX)}),
      .q(stat_s)
   );

   // Held words: each is stable long before its event is seen across
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_hold_reg <= BYTE_RST;
         rx_buf_reg <= BYTE_RST;
         rbf_seen_reg <= 1'b0;
      end else begin
         tx_hold_reg <= tx_write ? tx_data : tx_hold_reg;
         rx_buf_reg <= (stat_s[4] && !rbf_seen_reg) ? rx_word_reg : rx_buf_reg;
         rbf_seen_reg <= stat_s[4];
      end
   end

   assign rx_buffer = rx_buf_reg;
   assign {tx_buffer_full, rx_buffer_full, scl_release, rx_overflow,
           full_ten_bit_match, addressed_state} = stat_s;

   // ****************************************
   // Checks
   // ****************************************
   sequence rx_byte_s;
      byte_done && st_reg == ST_RX;
   endsequence
   sequence tx_ninth_s;
      ninth && st_reg == ST_TX;
   endsequence

   rx_full_nack_a: assert property (@(posedge link_clk) disable iff (lrst)
      rx_byte_s ##0 rbf_reg |=> !ack_reg && ov_reg && $stable(rx_word_reg))
      else $error("full buffer byte was acknowledged or stored");
   rx_load_ack_a: assert property (@(posedge link_clk) disable iff (lrst)
      rx_byte_s ##0 (!rbf_reg && !ov_reg) |=> ack_reg && rbf_reg && sda_oe_reg
         && rx_word_reg == $past(shift_reg))
      else $error("received byte not loaded and acknowledged");
   rx_ov_load_a: assert property (@(posedge link_clk) disable iff (lrst)
      rx_byte_s ##0 (!rbf_reg && ov_reg) |=> !ack_reg && rx_word_reg == $past(shift_reg))
      else $error("overflow byte handled wrongly");
   tx_stretch_a: assert property (@(posedge link_clk) disable iff (lrst)
      tx_ninth_s ##0 (ack_smp_reg && !tbf_reg && !rel_set_ev) |=> !rel_reg ##1 scl_oe_reg)
      else $error("transmit stretch missing");
   tx_no_stretch_a: assert property (@(posedge link_clk) disable iff (lrst)
      tx_ninth_s ##0 (tbf_reg && !rel_clr_ev) |=> rel_reg == $past(rel_reg))
      else $error("release cleared with transmit data present");
   tx_event_a: assert property (@(posedge link_clk) disable iff (lrst)
      tx_ninth_s |=> ev_reg)
      else $error("transmit event pulse missing");
   rx_stretch_a: assert property (@(posedge link_clk) disable iff (lrst)
      ninth && st_reg == ST_RX && rx_stretch_enable_s && rbf_reg && !rd_ev && !rel_set_ev |=> !rel_reg)
      else $error("receive stretch missing");
   ten_miss_a: assert property (@(posedge link_clk) disable iff (lrst)
      byte_done && st_reg == ST_ADDR && ten_s && !m10h |=> st_reg == ST_IDLE && !match_reg)
      else $error("ten-bit mismatch did not go idle");
   stop_idle_a: assert property (@(posedge link_clk) disable iff (lrst)
      stop_det |=> st_reg == ST_IDLE && !sda_oe_reg && rel_reg ##1 !scl_oe_reg)
      else $error("stop did not release the bus");
   rel_set_a: assert property (@(posedge link_clk) disable iff (lrst)
      rel_set_ev |=> rel_reg)
      else $error("release set was lost");
   rel_ignore_a: assert property (@(posedge link_clk) disable iff (lrst)
      rel_clr_ev && !rx_stretch_enable_s && !ninth |=> !$fell(rel_reg))
      else $error("release clear acted with stretching off");
endmodule
`default_nettype wire

// file: src/sync_filter.sv
// Three-stage synchroniser whose output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module sync_filter #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] q_reg;
   logic [WIDTH-1:0] q_next;

   // A bit changes only when the last two stages agree
   always_comb begin
      q_next = q_reg;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            q_next[i] = s3_reg[i];
         end
      end
   end

   // Stage one is read by stage two alone
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         q_reg <= INIT;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule
`default_nettype wire

// file: verif/bus_master_model.sv
// Behavioural two-wire bus master that faces the slave engine
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
   // Link clock and resolved bus levels
   input wire logic link_clk,
   input wire logic scl,
   input wire logic sda,
   // Line pulls, high pulls the line low, and the stretch timeout flag
   output logic scl_pull,
   output logic sda_pull,
   output logic stuck
);
   localparam int HALF = 10;
   // Both lines released at start
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      stuck = 1'b0;
   end
   // Release SCL and wait, bounded, while the slave stretches
   // Lines move on the falling link clock, away from the slave's sampling edge
   task automatic rise();
      int n;
      n = 0;
      scl_pull = 1'b0;
      while (scl !== 1'b1 && n < 4000) begin
         @(negedge link_clk);
         n++;
      end
      if (n >= 4000) stuck = 1'b1;
      repeat (HALF) @(negedge link_clk);
   endtask
   // Start or repeated start; SDA moves only well after SCL fell
   task automatic start();
      repeat (4) @(negedge link_clk);
      sda_pull = 1'b0;
      repeat (HALF) @(negedge link_clk);
      rise();
      sda_pull = 1'b1;
      repeat (HALF) @(negedge link_clk);
      scl_pull = 1'b1;
   endtask
   // Stop condition
   task automatic stop();
      repeat (4) @(negedge link_clk);
      sda_pull = 1'b1;
      repeat (HALF) @(negedge link_clk);
      rise();
      sda_pull = 1'b0;
      repeat (HALF) @(negedge link_clk);
   endtask
   // One bit: drive b, sample the line at the end of the high, just before SCL falls
   task automatic bitx(input logic b, output logic r);
      repeat (4) @(negedge link_clk);
      sda_pull = ~b;
      repeat (HALF) @(negedge link_clk);
      rise();
      r = sda;
      scl_pull = 1'b1;
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic r);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(a, r);
   endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the two-wire slave transfer engine
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import i2c_slave_pkg::*;
   logic core_clk, link_clk, rst, ten_bit_address_mode, rx_stretch_enable;
   logic [ADDR_W-1:0] own_address;
   logic [4:0] req;
   logic [BYTE_W-1:0] tx_data, rx_buffer, q;
   logic scl_oe, sda_oe, m_scl, m_sda, stuck, ack, tx_buffer_full, rx_buffer_full;
   logic rx_overflow, scl_release, full_ten_bit_match, addressed_state, slave_event_flag;
   wire scl, sda;
   int bad_count, cmp_count, ev_count;
   // Open-drain lines with pull-up
   assign scl = ~(m_scl | scl_oe);
   assign sda = ~(m_sda | sda_oe);
   i2c_slave_stretch_engine i2c_slave_stretch_engine_inst (
      .core_clk(core_clk), .rst(rst), .link_clk(link_clk),
      .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .own_address(own_address), .ten_bit_address_mode(ten_bit_address_mode),
      .rx_stretch_enable(rx_stretch_enable), .tx_write(req[0]), .tx_data(tx_data),
      .rx_read(req[2]), .scl_release_set(req[3]), .scl_release_clear(req[1]),
      .rx_overflow_clear(req[4]), .rx_buffer(rx_buffer), .tx_buffer_full(tx_buffer_full),
      .rx_buffer_full(rx_buffer_full), .rx_overflow(rx_overflow), .scl_release(scl_release),
      .full_ten_bit_match(full_ten_bit_match), .addressed_state(addressed_state),
      .slave_event_flag(slave_event_flag));
   bus_master_model bus_master_model_inst (
      .link_clk(link_clk), .scl(scl), .sda(sda),
      .scl_pull(m_scl), .sda_pull(m_sda), .stuck(stuck));
   // Core and link clocks, unrelated in phase
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.1;
      forever #6 link_clk = ~link_clk;
   end
   // Count ninth-clock event pulses
   always @(negedge core_clk) begin
      if (slave_event_flag === 1'b1) ev_count++;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle processor request, then spacing
   task automatic pulse(input int k);
      @(negedge core_clk);
      req[k] = 1'b1;
      @(negedge core_clk);
      req[k] = 1'b0;
      repeat (12) @(negedge core_clk);
   endtask
   task automatic settle();
      repeat (40) @(negedge core_clk);
   endtask
   task automatic wb(input logic [7:0] d, input logic e);
      bus_master_model_inst.xfer(d, 1'b1, q, ack);
      chk(ack, e);
      settle();
   endtask
   task automatic rb(input logic a, input logic [7:0] e);
      bus_master_model_inst.xfer(8'hFF, a, q, ack);
      chk(q, e);
      settle();
   endtask
   task automatic summarize();
      if (stuck === 1'b1) begin
         bad_count++;
         $display("BAD %0t bus master timed out on a stretch", $time);
      end
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      bad_count++;
      $display("BAD %0t run limit reached", $time);
      summarize();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      req = 5'h00;
      tx_data = 8'h00;
      own_address = 10'h02A;
      ten_bit_address_mode = 1'b0;
      rx_stretch_enable = 1'b1;
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      repeat (12) @(negedge core_clk);
      bus_master_model_inst.start();
      wb(8'h54, 1'b0);
      chk(rx_buffer_full, 1'b0);
      wb(8'hA5, 1'b0);
      chk(rx_buffer, 8'hA5);
      chk({scl_oe, scl_release}, 8'h02);
      pulse(3);
      wb(8'h3C, 1'b1);
      chk(rx_buffer, 8'hA5);
      chk(rx_overflow, 1'b1);
      pulse(2);
      pulse(3);
      wb(8'h5A, 1'b1);
      chk(rx_buffer, 8'h5A);
      pulse(3);
      bus_master_model_inst.stop();
      settle();
      chk({scl_oe, sda_oe, addressed_state}, 8'h00);
      bus_master_model_inst.start();
      wb(8'h56, 1'b1);
      bus_master_model_inst.stop();
      settle();
      rx_stretch_enable = 1'b0;
      settle();
      pulse(1);
      settle();
      chk(scl_release, 1'b1);
      bus_master_model_inst.start();
      wb(8'h55, 1'b0);
      chk(scl_oe, 1'b1);
      tx_data = 8'hC3;
      pulse(0);
      pulse(3);
      rb(1'b0, 8'hC3);
      chk({scl_oe, scl_release}, 8'h02);
      tx_data = 8'h96;
      pulse(0);
      pulse(3);
      rb(1'b1, 8'h96);
      bus_master_model_inst.stop();
      settle();
      ten_bit_address_mode = 1'b1;
      own_address = 10'h2B7;
      rx_stretch_enable = 1'b1;
      pulse(4);
      pulse(2);
      settle();
      chk(rx_overflow, 1'b0);
      bus_master_model_inst.start();
      wb(8'hF4, 1'b0);
      chk({full_ten_bit_match, scl_oe}, 8'h01);
      pulse(3);
      wb(8'hB7, 1'b0);
      chk(full_ten_bit_match, 1'b1);
      pulse(3);
      tx_data = 8'h4E;
      pulse(0);
      settle();
      chk(tx_buffer_full, 1'b1);
      bus_master_model_inst.start();
      wb(8'hF5, 1'b0);
      chk({scl_oe, tx_buffer_full}, 8'h00);
      pulse(3);
      rb(1'b1, 8'h4E);
      bus_master_model_inst.stop();
      bus_master_model_inst.start();
      wb(8'hF2, 1'b1);
      chk(full_ten_bit_match, 1'b0);
      bus_master_model_inst.stop();
      settle();
      chk(ev_count[7:0], 8'h0B);
      summarize();
   end
endmodule
`default_nettype wire
